// ==== src/adsq_top.sv ====
/*
 * Control of an 8-bit successive-approximation converter behind APB:
 * status/control, result and clock registers, channel routing,
 * single and continuous sequencing, done flag and interrupt request.
 * Assumes an external comparator reports input >= dac_code on
 * comparator_high, and that stop_mode is synchronous to pclk.
 */
// Contract
// - irq enable low: done flag read-only, set at every conversion end
// - done flag cleared by status write or result read
// - irq enable high: done bit is plain read/write service select
// - irq enable high: request raised at each conversion end
// - pending request dropped by result read or status write
// - reset clears done, irq enable and continuous bits
// - continuous mode: back-to-back conversions, result loaded each time
// - single mode: one conversion per start, then idle
// - codes 0-7 route port B pins, 8-14 port D pins 0-6
// - codes 0x0F-0x1A, 0x1C unused, 0x1B reserved: nothing routed
// - code 0x1D routes high reference, 0x1E low reference
// - all-ones channel powers converter down; reset sets all ones
// - one 8-bit result register overwritten at each completion
// - divide field: 1, 2, 4, 8, top bit set gives 16
// - source bit 1 bus clock, 0 crystal; reset selects crystal
// - status write starts conversion taking 16 to 17 converter clocks
// - continuous results overwrite earlier ones, read or not
// - stop mode aborts conversion and idles; restarts it from the first step on exit
`include "adsq_consts.svh"

module adsq_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crystal_clock,
    input wire logic stop_mode,
    input wire logic comparator_high,
    output logic [7:0] dac_code,
    output logic converting,
    output logic [7:0] port_b_select,
    output logic [6:0] port_d_select,
    output logic high_reference_select,
    output logic low_reference_select,
    output logic converter_power,
    output logic conv_irq
);
    adsq_clk_if clk_link ();

    adsq_clkdiv u_clkdiv (
        .pclk(pclk),
        .presetn(presetn),
        .crystal_clock(crystal_clock),
        .link(clk_link.div)
    );

    // register contents
    logic conv_done_flag;
    logic conv_irq_enable;
    logic continuous_select;
    adsq_pkg::adsq_channel_t input_channel_select;
    adsq_pkg::adsq_divide_t clock_divide_select;
    logic clock_source_select;
    logic [7:0] conversion_result;

    // sequencer state
    adsq_pkg::adsq_state_t state;
    logic [3:0] step;
    logic [7:0] sar;
    logic start_req;
    logic conv_end;

    // bus decode
    wire access = psel & penable & pready;
    wire hit_status = (paddr == `ADSQ_OFF_STATUS);
    wire hit_result = (paddr == `ADSQ_OFF_RESULT);
    wire hit_clock = (paddr == `ADSQ_OFF_CLOCK);
    wire hit_any = hit_status | hit_result | hit_clock;
    wire wr_status = access & pwrite & hit_status;
    wire wr_clock = access & pwrite & hit_clock;
    wire rd_result = access & ~pwrite & hit_result;

    wire [7:0] status_view = {conv_done_flag, conv_irq_enable,
                              continuous_select, input_channel_select};
    wire [7:0] clock_view = {clock_divide_select, clock_source_select,
                             4'h0};
    wire [7:0] read_byte = hit_status ? status_view :
                           hit_result ? conversion_result :
                           hit_clock ? clock_view : 8'h00;

    // sequencer conditions
    // stop and the power-off code both hold the converter idle
    wire power_off = (input_channel_select == `ADSQ_CODE_POWER_OFF);
    wire halted = power_off | stop_mode;
    wire tick = clk_link.conv_tick;
    // a status write in the same cycle takes priority; the start then
    // waits for the next converter tick
    wire begin_conv = (state == adsq_pkg::adsq_st_idle) & tick & ~halted &
                      ~wr_status & (start_req | continuous_select);
    wire last_step = (step == `ADSQ_CONV_LAST_STEP);
    wire finish = (state == adsq_pkg::adsq_st_convert) & tick & last_step &
                  ~halted & ~wr_status;
    wire [2:0] bit_idx = 3'h7 - step[3:1];

    // channel routing
    wire [4:0] ch = input_channel_select;
    wire route_b = (ch <= `ADSQ_CODE_PORTB_LAST);
    wire route_d = ~route_b & (ch <= `ADSQ_CODE_PORTD_LAST);
    wire [2:0] ch_low = ch[2:0];

    logic [7:0] next_sar;
    logic [7:0] next_port_b;
    logic [6:0] next_port_d;

    assign clk_link.source_select = clock_source_select;
    assign clk_link.divide_select = clock_divide_select;
    // divider restarts so a new ratio begins on a clean boundary
    assign clk_link.restart = wr_clock;
    assign conv_end = finish;

    // successive approximation: even step tries a bit, odd step judges it
    always_comb begin
        next_sar = sar;
        if (step[0]) begin
            if (!comparator_high) begin
                next_sar[bit_idx] = 1'b0;
            end
            if (bit_idx != 3'h0) begin
                next_sar[bit_idx - 3'h1] = 1'b1;
            end
        end
    end

    // one-hot pin routing; unused and reserved codes route nothing
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_route
            wire pin_hit = (ch_low == 3'(gi));
            assign next_port_b[gi] = route_b & pin_hit;
            if (gi < 7) begin : g_port_d
                assign next_port_d[gi] = route_d & pin_hit;
            end
        end
    endgenerate

    // apb answer: one wait state, then registered data and error
    wire answer = psel & penable & ~pready;
    wire [31:0] next_prdata = (answer & ~pwrite) ?
                              {24'h00_0000, read_byte} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= answer;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= answer & ~hit_any;
        end
    end

    // control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq_enable <= 1'b0;
            continuous_select <= 1'b0;
            input_channel_select <= `ADSQ_RST_CHANNEL;
        end else if (wr_status) begin
            conv_irq_enable <= pwdata[`ADSQ_BIT_IRQ_EN];
            continuous_select <= pwdata[`ADSQ_BIT_CONT];
            input_channel_select <= pwdata[`ADSQ_CHAN_HI:`ADSQ_CHAN_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_divide_select <= `ADSQ_RST_DIVIDE;
            clock_source_select <= `ADSQ_RST_SOURCE;
        end else if (wr_clock) begin
            clock_divide_select <= pwdata[`ADSQ_DIV_HI:`ADSQ_DIV_LO];
            clock_source_select <= pwdata[`ADSQ_BIT_SRC];
        end
    end

    // done flag: hardware set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_done_flag <= 1'b0;
        end else if (conv_irq_enable) begin
            if (wr_status) begin
                conv_done_flag <= pwdata[`ADSQ_BIT_DONE];
            end
        end else if (conv_end) begin
            conv_done_flag <= 1'b1;
        end else if (wr_status | rd_result) begin
            conv_done_flag <= 1'b0;
        end
    end

    // interrupt request, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq <= 1'b0;
        end else if (conv_end & conv_irq_enable) begin
            conv_irq <= 1'b1;
        end else if (wr_status | rd_result) begin
            conv_irq <= 1'b0;
        end
    end

    // result only changes at a conversion end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_result <= `ADSQ_RST_RESULT;
        end else if (conv_end) begin
            conversion_result <= next_sar;
        end
    end

    // stop during a conversion re-arms the start so the conversion restarts from step 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_req <= 1'b0;
        end else if (wr_status) begin
            start_req <= (pwdata[`ADSQ_CHAN_HI:`ADSQ_CHAN_LO] !=
                          `ADSQ_CODE_POWER_OFF);
        end else if (stop_mode & (state == adsq_pkg::adsq_st_convert)) begin
            start_req <= 1'b1;
        end else if (begin_conv) begin
            start_req <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= adsq_pkg::adsq_st_idle;
            step <= 4'h0;
            sar <= 8'h00;
        end else if (halted | wr_status) begin
            // a status write or stop abandons the running conversion
            state <= adsq_pkg::adsq_st_idle;
            step <= 4'h0;
        end else begin
            unique case (state)
                adsq_pkg::adsq_st_idle: begin
                    if (begin_conv) begin
                        state <= adsq_pkg::adsq_st_convert;
                        step <= 4'h0;
                        sar <= `ADSQ_SAR_FIRST;
                    end
                end
                adsq_pkg::adsq_st_convert: begin
                    if (tick) begin
                        sar <= next_sar;
                        step <= step + 4'h1;
                        if (last_step) begin
                            state <= adsq_pkg::adsq_st_idle;
                        end
                    end
                end
            endcase
        end
    end

    // registered pin-facing outputs; each lags its source by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= 8'h00;
        end else begin
            dac_code <= sar;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converting <= 1'b0;
        end else begin
            converting <= (state == adsq_pkg::adsq_st_convert);
        end
    end

    // routing follows the channel field, converting or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_select <= 8'h00;
        end else begin
            port_b_select <= next_port_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_d_select <= 7'h00;
        end else begin
            port_d_select <= next_port_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_reference_select <= 1'b0;
        end else begin
            high_reference_select <= (ch == `ADSQ_CODE_HIGH_REF);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_reference_select <= 1'b0;
        end else begin
            low_reference_select <= (ch == `ADSQ_CODE_LOW_REF);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_power <= 1'b0;
        end else begin
            converter_power <= ~halted;
        end
    end
endmodule

// ==== src/adsq_consts.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the
 * converter sequencer. Assumes a 32-bit APB with byte addresses.
 */
`ifndef ADSQ_CONSTS_SVH
`define ADSQ_CONSTS_SVH

`define ADSQ_ADDR_W 12
`define ADSQ_OFF_STATUS 12'h000
`define ADSQ_OFF_RESULT 12'h004
`define ADSQ_OFF_CLOCK 12'h008

`define ADSQ_BIT_DONE 7
`define ADSQ_BIT_IRQ_EN 6
`define ADSQ_BIT_CONT 5
`define ADSQ_CHAN_HI 4
`define ADSQ_CHAN_LO 0
`define ADSQ_DIV_HI 7
`define ADSQ_DIV_LO 5
`define ADSQ_BIT_SRC 4

`define ADSQ_RST_CHANNEL 5'h1f
`define ADSQ_RST_DIVIDE 3'h0
`define ADSQ_RST_SOURCE 1'b0
`define ADSQ_RST_RESULT 8'h00

`define ADSQ_CODE_PORTB_LAST 5'h07
`define ADSQ_CODE_PORTD_LAST 5'h0e
`define ADSQ_CODE_HIGH_REF 5'h1d
`define ADSQ_CODE_LOW_REF 5'h1e
`define ADSQ_CODE_POWER_OFF 5'h1f

`define ADSQ_CONV_LAST_STEP 4'hf
`define ADSQ_SAR_FIRST 8'h80

`endif

// ==== src/adsq_pkg.sv ====
/*
 * Types shared by the converter sequencer modules.
 * Assumes adsq_consts.svh supplies the numbers.
 */
package adsq_pkg;
    typedef enum logic {
        adsq_st_idle,
        adsq_st_convert
    } adsq_state_t;

    typedef logic [2:0] adsq_divide_t;
    typedef logic [4:0] adsq_channel_t;
endpackage

// ==== src/adsq_clk_if.sv ====
/*
 * Link between the sequencer core and its clock divider.
 * Assumes both ends run on pclk.
 */
interface adsq_clk_if;
    logic source_select;
    adsq_pkg::adsq_divide_t divide_select;
    logic restart;
    logic conv_tick;

    modport core (
        output source_select,
        output divide_select,
        output restart,
        input conv_tick
    );
    modport div (
        input source_select,
        input divide_select,
        input restart,
        output conv_tick
    );
endinterface

// ==== src/adsq_clkdiv.sv ====
/*
 * Converter clock: picks the bus clock or the crystal clock and divides
 * it by 1, 2, 4, 8 or 16 into a one-cycle enable on pclk.
 * Assumes crystal_clock is synchronous to pclk and slower than half pclk.
 */
`include "adsq_consts.svh"

module adsq_clkdiv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic crystal_clock,
    adsq_clk_if.div link
);
    logic crystal_prev;
    logic [3:0] count;
    logic [3:0] limit;
    logic in_tick;
    logic wrap;

    // one enable per rising crystal edge, or every bus cycle
    assign in_tick = link.source_select ? 1'b1 :
                     (crystal_clock & ~crystal_prev);
    // divide ratios 1, 2, 4, 8 and 16 for any code with the top bit set
    assign limit = link.divide_select[2] ? 4'hf :
                   link.divide_select[1] ?
                       (link.divide_select[0] ? 4'h7 : 4'h3) :
                       {3'h0, link.divide_select[0]};
    assign wrap = in_tick & (count >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_prev <= 1'b0;
        end else begin
            crystal_prev <= crystal_clock;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
            link.conv_tick <= 1'b0;
        end else if (link.restart) begin
            count <= 4'h0;
            link.conv_tick <= 1'b0;
        end else begin
            count <= wrap ? 4'h0 : (in_tick ? count + 4'h1 : count);
            link.conv_tick <= wrap;
        end
    end
endmodule

// ==== test/adsq_top_sva.sv ====
/* checker for adsq_top: apb answer timing, stop, irq clear, routing.
   assumes it is bound to adsq_top, one pclk domain. */
`include "adsq_consts.svh"
module adsq_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_mode,
    input wire logic converting,
    input wire logic [7:0] port_b_select,
    input wire logic [6:0] port_d_select,
    input wire logic high_reference_select,
    input wire logic low_reference_select,
    input wire logic converter_power,
    input wire logic conv_irq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // completed status write or result read while no conversion can end
    wire clr_acc = psel && penable && pready && !converting &&
        (pwrite ? paddr == `ADSQ_OFF_STATUS : paddr == `ADSQ_OFF_RESULT);
    wire [16:0] route = {port_b_select, port_d_select,
        high_reference_select, low_reference_select};
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    ready_wait_a: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready without a wait state");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside completion");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    rdata_byte_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    stop_power_a: assert property (stop_mode ##1 stop_mode |-> !converter_power)
        else $error("powered during stop");
    stop_idle_a: assert property (stop_mode [*3] |-> !converting)
        else $error("converting during stop");
    irq_clear_a: assert property (clr_acc |=> !conv_irq)
        else $error("irq kept after clear access");
    route_one_a: assert property ($onehot0(route))
        else $error("more than one input routed");
endmodule

bind adsq_top adsq_top_sva u_adsq_top_sva (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .stop_mode,
    .converting, .port_b_select, .port_d_select, .high_reference_select,
    .low_reference_select, .converter_power, .conv_irq);

// ==== test/adsq_top_tb_top.sv ====
/* directed bench for adsq_top over apb.
   assumes the bound checker; crystal runs at a quarter of pclk. */
`include "adsq_consts.svh"
module adsq_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic crystal_clock, stop_mode, comparator_high, converting;
    logic high_reference_select, low_reference_select;
    logic converter_power, conv_irq, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [7:0] port_b_select, dac_code;
    logic [6:0] port_d_select;
    logic [1:0] xcnt = 2'h0;
    int mismatches = 0;
    int total_checks = 0;
    int conv_len;
    adsq_top u_adsq_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .crystal_clock,
        .stop_mode, .comparator_high, .dac_code, .converting,
        .port_b_select, .port_d_select, .high_reference_select,
        .low_reference_select, .converter_power, .conv_irq);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        xcnt <= xcnt + 2'h1;
        crystal_clock <= xcnt[1];
    end
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task tout;
        mismatches++;
        $display("Error at %0t: wait ran out", $time);
        end_sim;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) tout;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rv, x);
    endtask
    // waits for converting to rise and fall, counting its high cycles
    task wait_end;
        int n;
        conv_len = 0;
        for (n = 0; n < 2000; n++) begin
            @(posedge pclk);
            #1;
            if (converting === 1'b1) conv_len++;
            else if (conv_len > 0) break;
        end
        if (n == 2000) tout;
    endtask
    task t_reset;
        rdc(`ADSQ_OFF_STATUS, 32'h1f);
        rdc(`ADSQ_OFF_CLOCK, 32'h0);
        rdc(`ADSQ_OFF_RESULT, 32'h0);
        chk(converter_power, 1'b0);
        $display("reset test done");
    endtask
    task t_single;
        comparator_high <= 1'b1;
        wr(`ADSQ_OFF_CLOCK, 32'h10);
        rdc(`ADSQ_OFF_CLOCK, 32'h10);
        wr(`ADSQ_OFF_STATUS, 32'h0);
        wait_end;
        chk(conv_len >= 16 && conv_len <= 17, 1'b1);
        chk(port_b_select, 8'h01);
        chk(converter_power, 1'b1);
        chk(dac_code, 8'hff);
        rdc(`ADSQ_OFF_STATUS, 32'h80);
        rdc(`ADSQ_OFF_RESULT, 32'hff);
        rdc(`ADSQ_OFF_RESULT, 32'hff);
        rdc(`ADSQ_OFF_STATUS, 32'h0);
        repeat (40) @(posedge pclk);
        chk(converting, 1'b0);
        $display("single test done");
    endtask
    task t_divide;
        int c, d;
        for (c = 0; c < 6; c++) begin
            d = (c > 3) ? 16 : (1 << c);
            wr(`ADSQ_OFF_CLOCK, {24'h0, c[2:0], 5'h10});
            wr(`ADSQ_OFF_STATUS, 32'h0);
            wait_end;
            chk(conv_len >= 16 * d && conv_len <= 17 * d + 1, 1'b1);
        end
        wr(`ADSQ_OFF_CLOCK, 32'h0);
        wr(`ADSQ_OFF_STATUS, 32'h0);
        wait_end;
        chk(conv_len >= 64 && conv_len <= 69, 1'b1);
        wr(`ADSQ_OFF_CLOCK, 32'h10);
        $display("divide test done");
    endtask
    task t_irq;
        comparator_high <= 1'b0;
        wr(`ADSQ_OFF_STATUS, 32'h48);
        wait_end;
        chk(conv_irq, 1'b1);
        chk(port_d_select, 7'h01);
        chk(dac_code, 8'h00);
        rdc(`ADSQ_OFF_STATUS, 32'h48);
        rdc(`ADSQ_OFF_RESULT, 32'h0);
        #1;
        chk(conv_irq, 1'b0);
        wr(`ADSQ_OFF_STATUS, 32'hce);
        wait_end;
        rdc(`ADSQ_OFF_STATUS, 32'hce);
        chk(port_d_select, 7'h40);
        wr(`ADSQ_OFF_STATUS, 32'h1f);
        @(posedge pclk);
        #1;
        chk(conv_irq, 1'b0);
        chk(converter_power, 1'b0);
        $display("irq test done");
    endtask
    task t_cont;
        comparator_high <= 1'b1;
        wr(`ADSQ_OFF_STATUS, 32'h3d);
        repeat (110) @(posedge pclk);
        #1;
        chk(converting, 1'b1);
        chk(high_reference_select, 1'b1);
        rdc(`ADSQ_OFF_STATUS, 32'hbd);
        rdc(`ADSQ_OFF_RESULT, 32'hff);
        comparator_high <= 1'b0;
        repeat (60) @(posedge pclk);
        rdc(`ADSQ_OFF_RESULT, 32'h0);
        wr(`ADSQ_OFF_STATUS, 32'h1e);
        wait_end;
        chk(low_reference_select, 1'b1);
        wr(`ADSQ_OFF_STATUS, 32'h0f);
        wait_end;
        chk({port_b_select, port_d_select, high_reference_select,
            low_reference_select}, 17'h0);
        $display("continuous test done");
    endtask
    task t_stop;
        comparator_high <= 1'b1;
        wr(`ADSQ_OFF_STATUS, 32'h0);
        repeat (6) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        chk(converting, 1'b0);
        chk(converter_power, 1'b0);
        @(posedge pclk);
        stop_mode <= 1'b0;
        wait_end;
        rdc(`ADSQ_OFF_STATUS, 32'h80);
        rdc(`ADSQ_OFF_RESULT, 32'hff);
        $display("stop test done");
    endtask
    task t_apb;
        apb(1'b0, 12'h00c, 32'h0);
        chk(ev, 1'b1);
        chk(rv, 32'h0);
        wr(`ADSQ_OFF_RESULT, 32'h55);
        chk(ev, 1'b0);
        rdc(`ADSQ_OFF_RESULT, 32'hff);
        $display("apb test done");
    endtask
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        stop_mode = 1'b0;
        comparator_high = 1'b0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_single;
        t_divide;
        t_irq;
        t_cont;
        t_stop;
        t_apb;
        end_sim;
    end
endmodule
